/* File: rtl/pst_pkg.sv */
// Package with constants for the pole-slip trip decision block.
package pst_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam logic [15:0] MS_CYCLES_W = 16'(MS_CYCLES);
  localparam logic [13:0] PULSE_MS_MIN = 14'h0032;
  localparam logic [13:0] PULSE_MS_MAX = 14'h2710;
  localparam logic [13:0] PULSE_MS_DEFAULT = 14'h0096;
  localparam logic [7:0] LIMIT_PCT_MIN = 8'h32;
  localparam logic [7:0] LIMIT_PCT_MAX = 8'hc8;
  localparam logic [7:0] LIMIT_PCT_DEFAULT = 8'h78;
  localparam int unsigned CUR_W = 16;
  localparam logic [2:0] NEG_SEQ_FACTOR = 3'h6;
  localparam logic [0:0] ENABLE_DEFAULT = 1'h0;
  localparam int unsigned REG_CTRL = 32'h00;
  localparam int unsigned REG_PULSE = 32'h04;
  localparam int unsigned REG_LIMIT = 32'h08;
  localparam int unsigned REG_STATE = 32'h0c;
  localparam int unsigned REG_IRQ_STATUS = 32'h10;
  localparam int unsigned REG_IRQ_MASK = 32'h14;
  localparam int unsigned IRQ_START_ON = 0;
  localparam int unsigned IRQ_START_OFF = 1;
  localparam int unsigned IRQ_TRIP_ON = 2;
  localparam int unsigned IRQ_TRIP_OFF = 3;
  typedef enum logic [0:0] {PST_IDLE, PST_PULSE} pst_state_type;
endpackage

/* File: rtl/pst_cur_cond.sv */
// Current-condition stage for one phase.
`timescale 1ns/1ps
`default_nettype none
module pst_cur_cond (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [pst_pkg::CUR_W-1:0] pos_seq_pct,
  input wire logic [pst_pkg::CUR_W-1:0] neg_seq_pct,
  input wire logic [7:0] pos_seq_current_limit,
  output logic current_ok
);
  import pst_pkg::*;
  wire logic pos_ok;
  wire logic neg_ok;
  wire logic [CUR_W+2:0] neg_scaled;
  assign pos_ok = pos_seq_pct > {8'h00, pos_seq_current_limit};
  assign neg_scaled = {3'h0, neg_seq_pct} * {16'h0000, NEG_SEQ_FACTOR};
  assign neg_ok = neg_scaled < {11'h000, pos_seq_current_limit};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      current_ok <= 1'b0;
    end else begin
      current_ok <= pos_ok && neg_ok;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pst_trip_logic.sv */
// Pole-slip trip decision with current qualification and register slave.
//
// Overview of operation
// - One pole-slip flag per phase-to-phase loop says the loop finished the set slip count.
// - A trip is decided only while at least two of the three loop flags are set together.
// - No trip is decided while blocked or while the function is disabled.
// - The enable setting is off or on, resets to off, and off disables everything.
// - The trip is a pulse whose length is the duration setting, 50 to 10000 ms, default 150.
// - While the block input is high the function does not operate.
// - Current is sufficient only when positive sequence exceeds the limit, 50 to 200, default 120.
// - Negative sequence must also be below one sixth of the limit.
// - Each phase has its own sufficiency flag feeding the trip logic.
// - Start and trip outputs exist and their on and off changes are reported as events.
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pst_trip_logic (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slip_flag_loop_a,
  input wire logic slip_flag_loop_b,
  input wire logic slip_flag_loop_c,
  input wire logic block_input,
  input wire logic [pst_pkg::CUR_W-1:0] pos_seq_a,
  input wire logic [pst_pkg::CUR_W-1:0] pos_seq_b,
  input wire logic [pst_pkg::CUR_W-1:0] pos_seq_c,
  input wire logic [pst_pkg::CUR_W-1:0] neg_seq_a,
  input wire logic [pst_pkg::CUR_W-1:0] neg_seq_b,
  input wire logic [pst_pkg::CUR_W-1:0] neg_seq_c,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic start_indication,
  output logic trip_command,
  output logic irq
);
  import pst_pkg::*;
  logic enable;
  logic [13:0] pulse_ms;
  logic [7:0] limit_pct;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [2:0] current_ok;
  logic vote_q;
  logic start_q;
  logic trip_q;
  logic [15:0] ms_div;
  logic [13:0] ms_count;
  logic acc_done;
  pst_state_type state;
  pst_state_type next_state;

  pst_cur_cond u_cond_a (.clk_sys(clk_sys), .rst_n(rst_n), .pos_seq_pct(pos_seq_a),
    .neg_seq_pct(neg_seq_a), .pos_seq_current_limit(limit_pct), .current_ok(current_ok[0]));
  pst_cur_cond u_cond_b (.clk_sys(clk_sys), .rst_n(rst_n), .pos_seq_pct(pos_seq_b),
    .neg_seq_pct(neg_seq_b), .pos_seq_current_limit(limit_pct), .current_ok(current_ok[1]));
  pst_cur_cond u_cond_c (.clk_sys(clk_sys), .rst_n(rst_n), .pos_seq_pct(pos_seq_c),
    .neg_seq_pct(neg_seq_c), .pos_seq_current_limit(limit_pct), .current_ok(current_ok[2]));

  // Loop a spans phases a,b; loop b spans b,c; loop c spans c,a.
  wire logic loop_a_ok;
  wire logic loop_b_ok;
  wire logic loop_c_ok;
  wire logic active;
  wire logic vote;
  wire logic vote_rise;
  wire logic next_start;
  wire logic ms_tick;
  wire logic pulse_end;
  assign loop_a_ok = slip_flag_loop_a && current_ok[0] && current_ok[1];
  assign loop_b_ok = slip_flag_loop_b && current_ok[1] && current_ok[2];
  assign loop_c_ok = slip_flag_loop_c && current_ok[2] && current_ok[0];
  assign active = enable && !block_input;
  assign vote = active && ((loop_a_ok && loop_b_ok) || (loop_b_ok && loop_c_ok)
    || (loop_c_ok && loop_a_ok));
  assign vote_rise = vote && !vote_q;
  assign next_start = active && (loop_a_ok || loop_b_ok || loop_c_ok);
  assign ms_tick = (ms_div == MS_CYCLES_W - 16'h0001);
  assign pulse_end = ms_tick && (ms_count == pulse_ms - 14'h0001);

  always_comb begin
    next_state = state;
    case (state)
      PST_IDLE: begin
        if (vote_rise) begin
          next_state = PST_PULSE;
        end
      end
      PST_PULSE: begin
        if (pulse_end || !active) begin
          next_state = PST_IDLE;
        end
      end
      default: begin
        next_state = PST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= PST_IDLE;
      vote_q <= 1'b0;
      start_q <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      state <= next_state;
      vote_q <= vote;
      start_q <= next_start;
      trip_q <= (next_state == PST_PULSE);
    end
  end

  // Millisecond divider and counter run only during the pulse.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_div <= 16'h0000;
      ms_count <= 14'h0000;
    end else if (state != PST_PULSE) begin
      ms_div <= 16'h0000;
      ms_count <= 14'h0000;
    end else if (ms_tick) begin
      ms_div <= 16'h0000;
      ms_count <= ms_count + 14'h0001;
    end else begin
      ms_div <= ms_div + 16'h0001;
    end
  end

  assign start_indication = start_q;
  assign trip_command = trip_q;

  // Register slave: one wait cycle per access.
  wire logic [6:0] byte_addr;
  wire logic acc;
  wire logic wr_go;
  wire logic pulse_lo;
  wire logic pulse_hi;
  wire logic limit_lo;
  wire logic limit_hi;
  wire logic wr_ctrl;
  wire logic wr_pulse;
  wire logic wr_limit;
  wire logic wr_status;
  wire logic wr_mask;
  wire logic [13:0] pulse_wr;
  wire logic [7:0] limit_wr;
  wire logic [3:0] events;
  wire logic [31:0] read_mux;
  assign byte_addr = {avs_address, 2'b00};
  assign acc = (avs_read || avs_write) && !acc_done;
  // A write lands on the edge at which the master sees waitrequest low.
  assign wr_go = avs_write && !avs_waitrequest;
  assign wr_ctrl = wr_go && byte_addr == 7'(REG_CTRL) && avs_byteenable[0];
  assign wr_pulse = wr_go && byte_addr == 7'(REG_PULSE) && (&avs_byteenable[1:0]);
  assign wr_limit = wr_go && byte_addr == 7'(REG_LIMIT) && avs_byteenable[0];
  assign wr_status = wr_go && byte_addr == 7'(REG_IRQ_STATUS) && avs_byteenable[0];
  assign wr_mask = wr_go && byte_addr == 7'(REG_IRQ_MASK) && avs_byteenable[0];
  // Out-of-range settings are clamped on the full written word, not a truncated one.
  assign pulse_lo = avs_writedata < 32'(PULSE_MS_MIN);
  assign pulse_hi = avs_writedata > 32'(PULSE_MS_MAX);
  assign limit_lo = avs_writedata < 32'(LIMIT_PCT_MIN);
  assign limit_hi = avs_writedata > 32'(LIMIT_PCT_MAX);
  assign pulse_wr = pulse_lo ? PULSE_MS_MIN :
    (pulse_hi ? PULSE_MS_MAX : avs_writedata[13:0]);
  assign limit_wr = limit_lo ? LIMIT_PCT_MIN :
    (limit_hi ? LIMIT_PCT_MAX : avs_writedata[7:0]);
  assign events = {(state == PST_PULSE) && (next_state != PST_PULSE),
    vote_rise && state == PST_IDLE, start_q && !next_start, !start_q && next_start};
  assign read_mux = byte_addr == 7'(REG_CTRL) ? {31'h0, enable} :
    byte_addr == 7'(REG_PULSE) ? {18'h0, pulse_ms} :
    byte_addr == 7'(REG_LIMIT) ? {24'h0, limit_pct} :
    byte_addr == 7'(REG_STATE) ? {24'h0, current_ok, slip_flag_loop_c, slip_flag_loop_b,
      slip_flag_loop_a, trip_q, start_q} :
    byte_addr == 7'(REG_IRQ_STATUS) ? {28'h0, irq_status} :
    byte_addr == 7'(REG_IRQ_MASK) ? {28'h0, irq_mask} : 32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      enable <= ENABLE_DEFAULT[0];
      pulse_ms <= PULSE_MS_DEFAULT;
      limit_pct <= LIMIT_PCT_DEFAULT;
      irq_mask <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        enable <= avs_writedata[0];
      end
      if (wr_pulse) begin
        pulse_ms <= pulse_wr;
      end
      if (wr_limit) begin
        limit_pct <= limit_wr;
      end
      if (wr_mask) begin
        irq_mask <= avs_writedata[3:0];
      end
    end
  end

  // Event bits are sticky; a new event wins over a write-one clear.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= 4'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~(wr_status ? avs_writedata[3:0] : 4'h0)) | events;
      irq <= |(((irq_status & ~(wr_status ? avs_writedata[3:0] : 4'h0)) | events) & irq_mask);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_done <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      acc_done <= acc;
      avs_waitrequest <= !acc;
      if (acc && avs_read) begin
        avs_readdata <= read_mux;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verif/pst_far_model.sv */
// Model of the loop evaluator and current measurement that feed the block.
`timescale 1ns/1ps
`default_nettype none
module pst_far_model (
  input wire logic clk_sys,
  input wire logic [2:0] want_flags,
  input wire logic [47:0] want_pos,
  input wire logic [47:0] want_neg,
  output logic [2:0] flags,
  output logic [47:0] pos,
  output logic [47:0] neg
);
  always_ff @(posedge clk_sys) begin
    flags <= want_flags;
    pos <= want_pos;
    neg <= want_neg;
  end
endmodule
`default_nettype wire

/* File: verif/pst_trip_logic_asserts.sv */
// Assertions on the ports of the pole-slip trip decision block.
`timescale 1ns/1ps
`default_nettype none
module pst_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic slip_flag_loop_a,
  input wire logic slip_flag_loop_b,
  input wire logic slip_flag_loop_c,
  input wire logic block_input,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic start_indication,
  input wire logic trip_command
);
  wire logic [1:0] n_fl = 2'(slip_flag_loop_a) + 2'(slip_flag_loop_b) + 2'(slip_flag_loop_c);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_trip_needs_vote: assert property ($rose(trip_command) |-> $past(n_fl) >= 2'h2)
    else $error("trip rose without two loop flags");
  a_block_clears_out: assert property (block_input |=> !trip_command && !start_indication)
    else $error("output active while blocked");
  a_start_needs_flag: assert property (start_indication |-> $past(n_fl) != 2'h0)
    else $error("start without any loop flag");
  a_trip_with_start: assert property ($rose(trip_command) |-> start_indication)
    else $error("trip rose without start");
  a_trip_pulse_holds: assert property (trip_command && !block_input && !avs_write
    && !$past(avs_write) && !$past(avs_write, 2) |=> trip_command)
    else $error("trip pulse ended early");
  a_wait_bounded: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest)
    else $error("bus access not answered");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (!avs_waitrequest && avs_read && avs_address > 5'h05
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind pst_trip_logic pst_chk u_chk (.*);
`default_nettype wire

/* File: verif/test_pole_slip_trip_decision.sv */
// Self-checking bench for the pole-slip trip decision block.
`timescale 1ns/1ps
`default_nettype none
module test_pole_slip_trip_decision;
  import pst_pkg::*;
  logic clk_sys = 1'h0, rst_n = 1'h0, block_input = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [4:0] avs_address = 5'h00;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd_val, seed = 32'h8f6e;
  logic avs_waitrequest, start_indication, trip_command, irq;
  logic [2:0] want_flags = 3'h0, flags;
  logic [47:0] want_pos = 48'h0, want_neg = 48'h0, pos, neg;
  logic [4:0] ra [5] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h07};
  logic [31:0] rv [5] = '{32'h0, 32'h96, 32'h78, 32'h0, 32'h0};
  logic [4:0] wa [5] = '{5'h01, 5'h01, 5'h02, 5'h02, 5'h02};
  logic [31:0] wv [5] = '{32'h0a, 32'h4e20, 32'h1e, 32'hfa, 32'h78};
  logic [31:0] we [5] = '{32'h32, 32'h2710, 32'h32, 32'hc8, 32'h78};
  int error_cnt = 0, n_tests = 0;
  pst_far_model far (.clk_sys, .want_flags, .want_pos, .want_neg, .flags, .pos, .neg);
  pst_trip_logic dut (.clk_sys, .rst_n, .slip_flag_loop_a(flags[0]), .slip_flag_loop_b(flags[1]),
    .slip_flag_loop_c(flags[2]), .block_input, .pos_seq_a(pos[15:0]), .pos_seq_b(pos[31:16]),
    .pos_seq_c(pos[47:32]), .neg_seq_a(neg[15:0]), .neg_seq_b(neg[31:16]), .neg_seq_c(neg[47:32]),
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .start_indication, .trip_command, .irq);
  initial forever #12.5 clk_sys = ~clk_sys;
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [2:0] exp_f(logic [2:0] f, logic [47:0] p, logic [47:0] n);
    logic [2:0] ok;
    logic [2:0] q;
    for (int i = 0; i < 3; i++)
      ok[i] = p[16*i+:16] > 16'h0078 && 32'(n[16*i+:16]) * 6 < 32'h78;
    q = f & ok & {ok[0], ok[2:1]};
    return {q == f, (q[0] & q[1]) | (q[1] & q[2]) | (q[0] & q[2]), |q};
  endfunction
  task automatic tally_and_finish(input int to);
    error_cnt += to;
    $display("errors %0d checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(logic wr, logic [4:0] a, logic [31:0] d);
    int k;
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys);
      if (!avs_waitrequest) break;
    end
    rd_val = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (k == 50) tally_and_finish(1);
    @(posedge clk_sys);
  endtask
  initial begin
    logic [47:0] np;
    logic [47:0] nn;
    logic [2:0] e;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      bus(0, ra[i], 32'h0);
      chk("reset value", rd_val, rv[i]);
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, wa[i], wv[i]);
      bus(0, wa[i], 32'h0);
      chk("setting", rd_val, we[i]);
    end
    avs_byteenable <= 4'h0;
    bus(1, 5'h02, 32'h40);
    avs_byteenable <= 4'hf;
    bus(0, 5'h02, 32'h0);
    chk("masked write", rd_val, 32'h78);
    want_pos <= {3{16'h0080}};
    want_neg <= {3{16'h0010}};
    want_flags <= 3'h7;
    repeat (5) @(posedge clk_sys);
    chk("trip off", trip_command, 1'h0);
    bus(1, 5'h00, 32'h1);
    repeat (3) @(posedge clk_sys);
    chk("trip on", {trip_command, start_indication, irq}, 3'h6);
    bus(0, 5'h04, 32'h0);
    chk("events", rd_val, 32'h5);
    bus(1, 5'h05, 32'hf);
    repeat (2) @(posedge clk_sys);
    chk("irq", irq, 1'h1);
    block_input <= 1'h1;
    repeat (3) @(posedge clk_sys);
    chk("blocked", {trip_command, start_indication}, 2'h0);
    bus(0, 5'h04, 32'h0);
    chk("events", rd_val, 32'hf);
    bus(1, 5'h04, 32'hf);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 1'h0);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      for (int j = 0; j < 3; j++) begin
        np[16*j+:16] = seed[31] ? 16'h0080 : 16'h0077 + 16'(seed[4*j+3+:2]);
        nn[16*j+:16] = seed[31] ? 16'h0010 : 16'h0011 + 16'(seed[4*j+5+:2]);
      end
      block_input <= 1'h1;
      want_flags <= seed[2:0];
      want_pos <= np;
      want_neg <= nn;
      repeat (5) @(posedge clk_sys);
      chk("start blocked", start_indication, 1'h0);
      block_input <= 1'h0;
      repeat (3) @(posedge clk_sys);
      e = exp_f(seed[2:0], np, nn);
      chk("start", start_indication, e[0]);
      chk("trip", trip_command, e[1]);
    end
    want_flags <= 3'h7;
    want_pos <= {3{16'h0080}};
    want_neg <= {3{16'h0010}};
    repeat (5) @(posedge clk_sys);
    bus(1, 5'h00, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("disabled", {trip_command, start_indication}, 2'h0);
    tally_and_finish(0);
  end
endmodule
`default_nettype wire
